/* rtl/dic_top.v */
// top of the eight-channel input conditioner with its wishbone register file.
// assumes present_channel_voltage comes from measurement logic on sys_clk.
//
// Summary of operation
// [RULE1] per-channel polarity select, open when idle default
// [RULE2] above activation level sets status per polarity
// [RULE3] below release level clears status per polarity
// [RULE4] rise delay in ms, default zero
// [RULE5] separate fall delay in ms, default zero
// [RULE6] alternating supply adds fixed 30 ms fall
// [RULE7] alternating supply forces release to tenth activation
// [RULE8] 32-bit tally counts delayed rising transitions
// [RULE9] clear command zeroes that channel's tally
// [RULE10] all channels evaluated once per 5 ms
// [RULE11] thresholds are software settable values
// [RULE12] eight independent channels with own settings
// [RULE13] present voltage readable in millivolts
// [RULE14] between levels previous comparison result holds
// [RULE15] tally follows delayed status, not raw comparisons
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.vh"

module dic_top #(
   parameter NCH = 8,
   parameter CYCLE_CLKS = `DIC_CYCLE_NS / `DIC_CLK_PERIOD_NS
) (
   input wire sys_clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [8:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [NCH*`DIC_VOLT_W-1:0] present_channel_voltage,
   output wire [NCH-1:0] input_channel_n
);

////////////////////////////////////////////////////////////////////////////////
// reset release through two flip-flops

reg rst_s1_r;
reg rst_s2_r;

always @(posedge sys_clk or negedge rst_n) begin
   if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
   end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
   end
end

wire rstn_i;
assign rstn_i = rst_s2_r;

////////////////////////////////////////////////////////////////////////////////
// processing-cycle divider

reg [23:0] div_r;
reg tick_r;

always @(posedge sys_clk or negedge rstn_i) begin
   if (!rstn_i) begin
      div_r <= 24'h000000;
      tick_r <= 1'b0;
   end else if (div_r == CYCLE_CLKS[23:0] - 24'h000001) begin
      div_r <= 24'h000000;
      tick_r <= 1'b1; // [RULE10]
   end else begin
      div_r <= div_r + 24'h000001;
      tick_r <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////////
// bus decode

wire req;
wire wr;
wire in_ch;
wire [3:0] ch_sel;
wire [2:0] reg_sel;
wire [31:0] be_mask;

assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
assign wr = req && wb_we_i;
assign in_ch = !wb_adr_i[8] && (wb_adr_i[7:5] < NCH);
assign ch_sel = {1'b0, wb_adr_i[7:5]};
assign reg_sel = wb_adr_i[4:2];
assign be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

function [31:0] merge;
   input [31:0] old_v;
   input [31:0] new_v;
   input [31:0] mask;
   begin
      merge = (old_v & ~mask) | (new_v & mask);
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// per-channel settings

reg pol_r [0:NCH-1];
reg ac_r [0:NCH-1];
reg [`DIC_LVL_W-1:0] act_r [0:NCH-1];
reg [`DIC_LVL_W-1:0] rel_r [0:NCH-1];
reg [`DIC_DLY_W-1:0] rise_r [0:NCH-1];
reg [`DIC_DLY_W-1:0] fall_r [0:NCH-1];
reg [NCH-1:0] clr_r;
wire [31:0] mrg_w;
integer i;

always @(posedge sys_clk or negedge rstn_i) begin
   if (!rstn_i) begin
      for (i = 0; i < NCH; i = i + 1) begin
         pol_r[i] <= 1'b0; // [RULE1]
         ac_r[i] <= 1'b0; // [RULE6]
         act_r[i] <= `DIC_ACT_RST; // [RULE2]
         rel_r[i] <= `DIC_REL_RST; // [RULE3]
         rise_r[i] <= `DIC_DLY_RST; // [RULE4]
         fall_r[i] <= `DIC_DLY_RST; // [RULE5]
      end
      clr_r <= {NCH{1'b0}};
   end else begin
      for (i = 0; i < NCH; i = i + 1) begin
         clr_r[i] <= 1'b0;
         if (wr && in_ch && ch_sel == i) begin // [RULE12]
            case (reg_sel)
               `DIC_OFS_CTRL: begin
                  pol_r[i] <= mrg_w[`DIC_CTRL_POL_BIT]; // [RULE1]
                  ac_r[i] <= mrg_w[`DIC_CTRL_AC_BIT]; // [RULE6]
               end
               `DIC_OFS_ACT: begin
                  act_r[i] <= mrg_w[`DIC_LVL_W-1:0]; // [RULE11]
               end
               `DIC_OFS_REL: begin
                  rel_r[i] <= mrg_w[`DIC_LVL_W-1:0]; // [RULE11]
               end
               `DIC_OFS_RISE: begin
                  rise_r[i] <= mrg_w[`DIC_DLY_W-1:0]; // [RULE4]
               end
               `DIC_OFS_FALL: begin
                  fall_r[i] <= mrg_w[`DIC_DLY_W-1:0]; // [RULE5]
               end
               `DIC_OFS_CLR: begin
                  clr_r[i] <= wb_sel_i[0] && wb_dat_i[`DIC_CLR_BIT]; // [RULE9]
               end
               default: begin
                  clr_r[i] <= 1'b0;
               end
            endcase
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// channel instances

wire [NCH*`DIC_TALLY_W-1:0] tally_w;
reg [`DIC_VOLT_W-1:0] volt_r [0:NCH-1];

genvar g;
generate
   for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // voltage held for readback so a read sees one coherent sample
      always @(posedge sys_clk or negedge rstn_i) begin
         if (!rstn_i) begin
            volt_r[g] <= 19'h00000;
         end else begin
            volt_r[g] <= present_channel_voltage[g*`DIC_VOLT_W +: `DIC_VOLT_W]; // [RULE13]
         end
      end

      dic_channel u_ch (
         .clk(sys_clk),
         .rst_n(rstn_i),
         .tick_en(tick_r),
         .pol_closed(pol_r[g]),
         .ac_mode(ac_r[g]),
         .act_lvl(act_r[g]),
         .rel_lvl(rel_r[g]),
         .rise_dly(rise_r[g]),
         .fall_dly(fall_r[g]),
         .volt_mv(volt_r[g]),
         .tally_clr(clr_r[g]),
         .status_r(input_channel_n[g]),
         .tally_r(tally_w[g*`DIC_TALLY_W +: `DIC_TALLY_W])
      );
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read mux; unmapped addresses answer with zero

reg [31:0] rd_nxt;
reg [2:0] ci;

always @* begin
   rd_nxt = 32'h00000000;
   ci = wb_adr_i[7:5];
   if (wb_adr_i == `DIC_ADR_STATUS) begin
      rd_nxt[NCH-1:0] = input_channel_n;
   end else if (in_ch) begin
      case (reg_sel)
         `DIC_OFS_CTRL: rd_nxt = {30'h0, ac_r[ci], pol_r[ci]};
         `DIC_OFS_ACT: rd_nxt = {20'h0, act_r[ci]};
         `DIC_OFS_REL: rd_nxt = {20'h0, rel_r[ci]};
         `DIC_OFS_RISE: rd_nxt = {11'h0, rise_r[ci]};
         `DIC_OFS_FALL: rd_nxt = {11'h0, fall_r[ci]};
         `DIC_OFS_TALLY: rd_nxt = tally_w[ci*`DIC_TALLY_W +: `DIC_TALLY_W]; // [RULE8]
         `DIC_OFS_VOLT: rd_nxt = {13'h0, volt_r[ci]}; // [RULE13]
         default: rd_nxt = 32'h00000000;
      endcase
   end
end

// byte-lane merge reuses the read mux, so a partial write keeps the live unselected byte lanes
assign mrg_w = merge(rd_nxt, wb_dat_i, be_mask);

// one wait state: ack the cycle after the request, drop it the cycle after
always @(posedge sys_clk or negedge rstn_i) begin
   if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
   end else begin
      wb_ack_o <= req;
      if (req) begin
         wb_dat_o <= rd_nxt;
      end
   end
end

endmodule
`default_nettype wire

/* pkg/dic_defs.vh */
// constants of the eight-channel input conditioner: register map, field
// positions, reset values and timing figures.
// assumes a 125 MHz system clock and word-aligned classic wishbone access.
`ifndef DIC_DEFS_VH
`define DIC_DEFS_VH

// clock and processing cycle
`define DIC_CLK_PERIOD_NS 8
`define DIC_CYCLE_NS 5000000
`define DIC_CYCLE_MS 22'h000005
`define DIC_AC_DELAY_MS 22'h00001E

// widths
`define DIC_LVL_W 12
`define DIC_DLY_W 21
`define DIC_VOLT_W 19
`define DIC_TALLY_W 32
`define DIC_TMR_W 22

// level scaling: levels in 0.1 V, voltage in 1 mV
`define DIC_MV_PER_LVL 100
`define DIC_AC_MV_PER_LVL 10

// reset values
`define DIC_ACT_RST 12'h370
`define DIC_REL_RST 12'h258
`define DIC_DLY_RST 21'h000000

// per-channel block: channel n at byte address n * 0x20
`define DIC_CH_STRIDE_BITS 5
`define DIC_OFS_CTRL 3'h0
`define DIC_OFS_ACT 3'h1
`define DIC_OFS_REL 3'h2
`define DIC_OFS_RISE 3'h3
`define DIC_OFS_FALL 3'h4
`define DIC_OFS_TALLY 3'h5
`define DIC_OFS_CLR 3'h6
`define DIC_OFS_VOLT 3'h7
// global status word of all delayed channel states
`define DIC_ADR_STATUS 9'h100

// fields of the control word and the clear command
`define DIC_CTRL_POL_BIT 0
`define DIC_CTRL_AC_BIT 1
`define DIC_CLR_BIT 0

`endif

/* rtl/dic_channel.v */
// one input channel: hysteresis comparison, polarity, rise and fall delay
// timing and the rising-edge tally.
// assumes tick_en is a one-cycle pulse per processing cycle on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.vh"

module dic_channel (
   input wire clk,
   input wire rst_n,
   input wire tick_en,
   input wire pol_closed,
   input wire ac_mode,
   input wire [`DIC_LVL_W-1:0] act_lvl,
   input wire [`DIC_LVL_W-1:0] rel_lvl,
   input wire [`DIC_DLY_W-1:0] rise_dly,
   input wire [`DIC_DLY_W-1:0] fall_dly,
   input wire [`DIC_VOLT_W-1:0] volt_mv,
   input wire tally_clr,
   output reg status_r,
   output reg [`DIC_TALLY_W-1:0] tally_r
);

////////////////////////////////////////////////////////////////////////////////
// thresholds in millivolts

wire [19:0] act_mv;
wire [19:0] rel_set_mv;
wire [19:0] rel_ac_mv;
wire [19:0] rel_mv;
wire [19:0] volt_ext;

assign act_mv = {8'h00, act_lvl} * 20'h00064;
assign rel_set_mv = {8'h00, rel_lvl} * 20'h00064;
assign rel_ac_mv = {8'h00, act_lvl} * 20'h0000A;
assign rel_mv = ac_mode ? rel_ac_mv : rel_set_mv; // [RULE7]
assign volt_ext = {1'b0, volt_mv};

////////////////////////////////////////////////////////////////////////////////
// comparison and delay timing, all advanced only on the cycle tick

reg cmp_r;
reg [`DIC_TMR_W-1:0] tmr_r;
wire target;
wire [`DIC_TMR_W-1:0] fall_need;
wire [`DIC_TMR_W-1:0] need;
wire rise_evt;

assign target = cmp_r ^ pol_closed; // [RULE1] [RULE2] [RULE3]
// alternating supply stretches the release so a mains zero crossing is bridged
assign fall_need = {1'b0, fall_dly} + (ac_mode ? `DIC_AC_DELAY_MS : 22'h000000); // [RULE6]
assign need = target ? {1'b0, rise_dly} : fall_need; // [RULE4] [RULE5]
assign rise_evt = tick_en && target && !status_r && (tmr_r >= need);

always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      cmp_r <= 1'b0;
      tmr_r <= 22'h000000;
      status_r <= 1'b0;
   end else if (tick_en) begin // [RULE10]
      if (volt_ext > act_mv) begin
         cmp_r <= 1'b1; // [RULE2]
      end else if (volt_ext < rel_mv) begin
         cmp_r <= 1'b0; // [RULE3]
      end
      // between the levels the last result stands
      if (target == status_r) begin
         tmr_r <= 22'h000000; // [RULE14] [RULE15]
      end else if (tmr_r >= need) begin
         status_r <= target; // [RULE4] [RULE5]
         tmr_r <= 22'h000000;
      end else begin
         tmr_r <= tmr_r + `DIC_CYCLE_MS;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// tally of delayed rising transitions; a coincident edge counts as one after the clear

always @(posedge clk or negedge rst_n) begin
   if (!rst_n) begin
      tally_r <= 32'h00000000;
   end else if (tally_clr) begin
      tally_r <= rise_evt ? 32'h00000001 : 32'h00000000; // [RULE9]
   end else if (rise_evt) begin
      tally_r <= tally_r + 32'h00000001; // [RULE8] [RULE15]
   end
end

endmodule
`default_nettype wire

/* testbench/dic_meas_model.sv */
// voltage front end model: one held millivolt figure per channel.
// assumes the bench sets levels through set_mv.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.vh"
module dic_meas_model #(
   parameter NCH = 8
) (
   input wire logic clk,
   output logic [NCH*`DIC_VOLT_W-1:0] volt
);
   initial volt = '0;
   // lands just after an edge, like a same-clock source
   task automatic set_mv(input int ch, input logic [`DIC_VOLT_W-1:0] mv);
      @(posedge clk);
      volt[ch*`DIC_VOLT_W +: `DIC_VOLT_W] <= mv;
   endtask
endmodule
`default_nettype wire

/* testbench/dic_checker.sv */
// assertions on the conditioner top: bus handshake, read-back and status timing.
// assumes one clock and the tick period CYCLE_CLKS of the bound instance.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.vh"
module dic_checker #(
   parameter NCH = 8,
   parameter CYCLE_CLKS = 625000
) (
   input wire sys_clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [8:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire [NCH*`DIC_VOLT_W-1:0] present_channel_voltage,
   input wire [NCH-1:0] input_channel_n
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [NCH-1:0] prev_r;
   logic [NCH*`DIC_VOLT_W-1:0] vq_r;
   logic [`DIC_VOLT_W-1:0] vsel_r;
   int gap_r;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= '0;
         gap_r <= 0;
      end else begin
         prev_r <= input_channel_n;
         gap_r <= (input_channel_n != prev_r) ? 0 : gap_r + 1;
      end
   end
   // voltage shadow, one register deep like the design's input stage
   always @(posedge sys_clk) begin
      vq_r <= present_channel_voltage;
      vsel_r <= vq_r[wb_adr_i[7:5]*`DIC_VOLT_W +: `DIC_VOLT_W];
   end
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence read_s;
      take_s ##0 !wb_we_i;
   endsequence
   ack_after_req_a: assert property (take_s |=> wb_ack_o) else $error("ack missing");
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   status_gap_a: assert property (input_channel_n != prev_r |->
      gap_r >= CYCLE_CLKS - 1) else $error("status moved between ticks");
   status_reset_a: assert property ($rose(rst_n) |-> (input_channel_n == '0) [*2])
      else $error("status not clear after reset");
   status_read_a: assert property (read_s ##0 wb_adr_i == 9'h100 |=>
      wb_dat_o == {24'h0, $past(input_channel_n)}) else $error("status word wrong");
   volt_read_a: assert property (read_s ##0 {wb_adr_i[8], wb_adr_i[4:0]} == 6'h1C |=>
      wb_dat_o == {13'h0, vsel_r}) else $error("voltage reading wrong");
   unmapped_read_a: assert property (read_s ##0 wb_adr_i > 9'h103 |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
endmodule
bind dic_top dic_checker #(.NCH(NCH), .CYCLE_CLKS(CYCLE_CLKS)) chk_u (.sys_clk(sys_clk),
   .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .present_channel_voltage(present_channel_voltage), .input_channel_n(input_channel_n));
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the conditioner: register access and channel timing.
// assumes a short processing cycle of C clocks and the front end model.
`timescale 1ns/1ps
`default_nettype none
`include "dic_defs.vh"
module tb_top;
   localparam int C = 20;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [8:0] wb_adr_i = 9'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] rd_v;
   logic wb_ack_o;
   logic [8*`DIC_VOLT_W-1:0] volt;
   logic [7:0] status;
   int mismatches = 0;
   int n_compared = 0;
   always #4 sys_clk = ~sys_clk;
   dic_meas_model meas_u (.clk(sys_clk), .volt(volt));
   dic_top #(.CYCLE_CLKS(C)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .present_channel_voltage(volt), .input_channel_n(status));
////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // no fixed ack latency assumed; the watchdog ends a stuck wait
   task automatic xfer(input logic we, input logic [8:0] a, input logic [31:0] d,
         input logic [3:0] s);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
      rd_v = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, 4'hF);
      check(rd_v, exp);
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hF);
   endtask
   task automatic wait_lvl(input int ch, input logic lvl, input int lo, input int hi);
      int n;
      n = 0;
      while (status[ch] !== lvl && n <= hi) begin
         @(posedge sys_clk);
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   // status moves ticks after the comparator does, one tick of slack
   task automatic step(input int ch, input logic [18:0] mv, input logic lvl, input int t);
      meas_u.set_mv(ch, mv);
      wait_lvl(ch, lvl, t * C, t * C + C + 4);
   endtask
   task automatic hold(input int ch, input logic [18:0] mv, input logic lvl);
      meas_u.set_mv(ch, mv);
      repeat (3 * C) @(posedge sys_clk);
      check({31'h0, status[ch]}, {31'h0, lvl});
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(9'h004, 32'h370);
      rd(9'h008, 32'h258);
      rd(9'h00C, 32'h0);
      rd(9'h010, 32'h0);
      rd(9'h000, 32'h0);
      hold(0, 19'h157C0, 1'b0);
      step(0, 19'h157C1, 1'b1, 1);
      hold(0, 19'h0EA60, 1'b1);
      step(0, 19'h0EA5F, 1'b0, 1);
      rd(9'h014, 32'h1);
      rd(9'h01C, 32'hEA5F);
      wr(9'h018, 32'h1);
      rd(9'h014, 32'h0);
      wr(9'h020, 32'h1);
      wait_lvl(1, 1'b1, 0, 2 * C + 4);
      step(1, 19'h186A0, 1'b0, 1);
      rd(9'h034, 32'h1);
      wr(9'h04C, 32'h14);
      wr(9'h050, 32'hA);
      step(2, 19'h15F90, 1'b1, 5);
      step(2, 19'h0, 1'b0, 3);
      wr(9'h060, 32'h2);
      step(3, 19'h15F90, 1'b1, 1);
      hold(3, 19'h2328, 1'b1);
      step(3, 19'h225F, 1'b0, 7);
      wr(9'h08C, 32'h14);
      meas_u.set_mv(4, 19'h15F90);
      repeat (2 * C) @(posedge sys_clk);
      hold(4, 19'h0, 1'b0);
      rd(9'h094, 32'h0);
      xfer(1'b1, 9'h0A4, 32'hFFF, 4'h1);
      rd(9'h0A4, 32'h3FF);
      wr(9'h0A4, 32'h64);
      step(5, 19'h2711, 1'b1, 1);
      // a programmed release level above the default must drop the status
      wr(9'h0C8, 32'h2EE);
      rd(9'h0C8, 32'h2EE);
      step(6, 19'h15F90, 1'b1, 1);
      step(6, 19'h124F7, 1'b0, 1);
      wr(9'h104, 32'hFFFF);
      rd(9'h104, 32'h0);
      rd(9'h100, 32'h20);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
